// ---- common/perc_pkg.sv ----
// Purpose: shared constants for the receive error counter and coding-sublayer control bank
// Assumes: apb slave, 32-bit data, 125 MHz clock
// Notes:   offsets are register indices; byte address is four times the index
package perc_pkg;
  // -------------------------------------------------------------------------
  // register map
  // -------------------------------------------------------------------------
  localparam logic [7:0]  IDX_RX_ERR     = 8'h15;
  localparam logic [7:0]  IDX_PCS_CFG    = 8'h16;
  localparam logic [7:0]  IDX_LINK_STAT  = 8'h18;
  localparam logic [11:0] ADDR_RX_ERR    = {2'h0, IDX_RX_ERR, 2'h0};
  localparam logic [11:0] ADDR_PCS_CFG   = {2'h0, IDX_PCS_CFG, 2'h0};
  localparam logic [11:0] ADDR_LINK_STAT = {2'h0, IDX_LINK_STAT, 2'h0};
  // -------------------------------------------------------------------------
  // coding-sublayer field positions and reset
  // -------------------------------------------------------------------------
  localparam int          BIT_FREE_CLK   = 11;
  localparam int          BIT_QUIET_EN   = 10;
  localparam int          BIT_SD_FORCE   = 9;
  localparam int          BIT_SD_POLICY  = 8;
  localparam int          BIT_DESC_TMO   = 7;
  localparam int          BIT_FORCE_OK   = 5;
  localparam int          BIT_NRZI_BYP   = 2;
  localparam logic [15:0] PCS_WMASK      = 16'h0fa4;
  localparam logic [15:0] PCS_RESET      = 16'h0100;
  localparam logic [7:0]  ERR_MAX        = 8'hff;
  // -------------------------------------------------------------------------
  // descrambler timeouts
  // -------------------------------------------------------------------------
  localparam int          CLK_MHZ        = 125;
  localparam int          DESC_SHORT_US  = 722;
  localparam int          DESC_LONG_US   = 2000;
  localparam int          DESC_SHORT_CYC = DESC_SHORT_US * CLK_MHZ;
  localparam int          DESC_LONG_CYC  = DESC_LONG_US * CLK_MHZ;
  localparam int          TMO_W          = 18;
endpackage : perc_pkg

// ---- core/perc_sync.sv ----
// Purpose: two-flop synchroniser for a bundle of level inputs
// Assumes: inputs asynchronous to clk
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module perc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // data
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s1_nxt;
  logic [W-1:0] q_nxt;

  always_comb begin
    s1_nxt = d;
    q_nxt  = s1_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      q    <= '0;
    end else begin
      s1_r <= s1_nxt;
      q    <= q_nxt;
    end
  end
endmodule : perc_sync
`default_nettype wire

// ---- core/perc_top.sv ----
// Purpose: receive error counter and 100 Mb/s coding-sublayer control registers
// Assumes: apb slave, single 125 MHz clock, async active-low reset
// Notes:   datapath inputs are synchronised before use
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module perc_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // receive path status
  input  wire logic        rx_carrier,
  input  wire logic        rx_symbol_err,
  input  wire logic        rx_collision,
  input  wire logic        signal_level_ok,
  input  wire logic        desc_locked,
  input  wire logic        desc_activity,
  // datapath controls
  output var  logic        true_quiet_enable,
  output var  logic        forced_signal_detect,
  output var  logic        descrambler_timeout_select,
  output var  logic        nrzi_bypass,
  output var  logic        free_rx_clock,
  output var  logic        link_100_up,
  output var  logic        desc_timeout
);
  // -------------------------------------------------------------------------
  // input synchronisation
  // -------------------------------------------------------------------------
  logic [5:0] raw_in;
  logic [5:0] syn;
  assign raw_in = {rx_carrier, rx_symbol_err, rx_collision,
                   signal_level_ok, desc_locked, desc_activity};
  perc_sync #(.W(6)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (raw_in),
    .q     (syn)
  );
  logic car_s, err_s, col_s, sig_s, lock_s, act_s;
  assign {car_s, err_s, col_s, sig_s, lock_s, act_s} = syn;

  // -------------------------------------------------------------------------
  // apb decode
  // -------------------------------------------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a == r);
  endfunction : hit

  logic acc, wr_acc, rd_acc, rd_err, wr_cfg, known;
  assign acc    = psel && penable && pready;
  assign wr_acc = acc && pwrite;
  assign rd_acc = acc && !pwrite;
  assign known  = hit(paddr, perc_pkg::ADDR_RX_ERR) || hit(paddr, perc_pkg::ADDR_PCS_CFG)
                  || hit(paddr, perc_pkg::ADDR_LINK_STAT);
  assign rd_err = rd_acc && hit(paddr, perc_pkg::ADDR_RX_ERR);
  assign wr_cfg = wr_acc && hit(paddr, perc_pkg::ADDR_PCS_CFG);

  // -------------------------------------------------------------------------
  // receive error counter
  // -------------------------------------------------------------------------
  logic [7:0] cnt_r, cnt_nxt;
  logic       car_d_r, car_d_nxt;
  logic       ev_err_r, ev_err_nxt;
  logic       ev_col_r, ev_col_nxt;
  logic       ev_done_r, ev_done_nxt;
  logic       bump;

  always_comb begin
    car_d_nxt   = car_s;
    ev_err_nxt  = ev_err_r;
    ev_col_nxt  = ev_col_r;
    ev_done_nxt = ev_done_r;
    bump        = 1'b0;
    if (car_s && !car_d_r) begin
      ev_err_nxt  = err_s;
      ev_col_nxt  = col_s;
      ev_done_nxt = 1'b0;
    end else if (car_s) begin
      if (col_s) begin
        ev_col_nxt = 1'b1;
      end
      if (err_s) begin
        ev_err_nxt = 1'b1;
      end
    end
    // count at end of carrier so a late collision still suppresses it
    if (!car_s && car_d_r && (ev_err_r || err_s) && !ev_col_r && !ev_done_r) begin
      bump        = 1'b1;
      ev_done_nxt = 1'b1;
    end
    cnt_nxt = cnt_r;
    if (rd_err) begin
      cnt_nxt = 8'h00;
    end
    if (bump) begin
      if (rd_err) begin
        cnt_nxt = 8'h01;
      end else if (cnt_r != perc_pkg::ERR_MAX) begin
        cnt_nxt = cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r     <= 8'h00;
      car_d_r   <= 1'b0;
      ev_err_r  <= 1'b0;
      ev_col_r  <= 1'b0;
      ev_done_r <= 1'b0;
    end else begin
      cnt_r     <= cnt_nxt;
      car_d_r   <= car_d_nxt;
      ev_err_r  <= ev_err_nxt;
      ev_col_r  <= ev_col_nxt;
      ev_done_r <= ev_done_nxt;
    end
  end

  // -------------------------------------------------------------------------
  // coding-sublayer configuration
  // -------------------------------------------------------------------------
  logic [15:0] cfg_r, cfg_nxt;

  always_comb begin
    cfg_nxt = cfg_r;
    if (wr_cfg) begin
      cfg_nxt = pwdata[15:0] & perc_pkg::PCS_WMASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= perc_pkg::PCS_RESET;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // -------------------------------------------------------------------------
  // link qualification
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PERC_DOWN = 2'b01,
    PERC_UP   = 2'b10
  } perc_link_e;
  perc_link_e lst_r, lst_nxt;

  always_comb begin
    lst_nxt = lst_r;
    case (lst_r)
      PERC_DOWN: begin
        if (sig_s && lock_s) begin
          lst_nxt = PERC_UP;
        end
      end
      PERC_UP: begin
        if (!sig_s) begin
          lst_nxt = PERC_DOWN;
        end else if (!cfg_r[perc_pkg::BIT_SD_POLICY] && !lock_s) begin
          lst_nxt = PERC_DOWN;
        end
      end
      default: lst_nxt = PERC_DOWN;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lst_r <= PERC_DOWN;
    end else begin
      lst_r <= lst_nxt;
    end
  end

  // -------------------------------------------------------------------------
  // descrambler timeout timer
  // -------------------------------------------------------------------------
  logic [perc_pkg::TMO_W-1:0] tmo_r, tmo_nxt, tmo_lim;
  logic                       tout_nxt;

  always_comb begin
    tmo_lim = cfg_r[perc_pkg::BIT_DESC_TMO] ?
              perc_pkg::TMO_W'(perc_pkg::DESC_LONG_CYC) :
              perc_pkg::TMO_W'(perc_pkg::DESC_SHORT_CYC);
    tout_nxt = 1'b0;
    if (act_s || !lock_s) begin
      tmo_nxt = '0;
    end else if (tmo_r >= tmo_lim - 1'b1) begin
      tmo_nxt  = '0;
      tout_nxt = 1'b1;
    end else begin
      tmo_nxt = tmo_r + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmo_r <= '0;
    end else begin
      tmo_r <= tmo_nxt;
    end
  end

  // -------------------------------------------------------------------------
  // outputs and read data
  // -------------------------------------------------------------------------
  logic [31:0] rdata_nxt;
  logic        link_nxt;

  always_comb begin
    link_nxt  = cfg_r[perc_pkg::BIT_FORCE_OK] || (lst_r == PERC_UP);
    rdata_nxt = 32'h0000_0000;
    if (hit(paddr, perc_pkg::ADDR_RX_ERR)) begin
      rdata_nxt = {24'h00_0000, cnt_r};
    end else if (hit(paddr, perc_pkg::ADDR_PCS_CFG)) begin
      rdata_nxt = {16'h0000, cfg_r};
    end else if (hit(paddr, perc_pkg::ADDR_LINK_STAT)) begin
      rdata_nxt = {31'h0000_0000, link_nxt};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready                     <= 1'b0;
      prdata                     <= 32'h0000_0000;
      pslverr                    <= 1'b0;
      true_quiet_enable          <= 1'b0;
      forced_signal_detect       <= 1'b0;
      descrambler_timeout_select <= 1'b0;
      nrzi_bypass                <= 1'b0;
      free_rx_clock              <= 1'b0;
      link_100_up                <= 1'b0;
      desc_timeout               <= 1'b0;
    end else begin
      pready                     <= psel && !penable;
      prdata                     <= rdata_nxt;
      pslverr                    <= psel && !penable && !known;
      true_quiet_enable          <= cfg_nxt[perc_pkg::BIT_QUIET_EN];
      forced_signal_detect       <= cfg_nxt[perc_pkg::BIT_SD_FORCE];
      descrambler_timeout_select <= cfg_nxt[perc_pkg::BIT_DESC_TMO];
      nrzi_bypass                <= cfg_nxt[perc_pkg::BIT_NRZI_BYP];
      free_rx_clock              <= cfg_nxt[perc_pkg::BIT_FREE_CLK];
      link_100_up                <= link_nxt;
      desc_timeout               <= tout_nxt;
    end
  end

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  chk_cnt_sat: assert property (@(posedge clk) disable iff (!rst_n)
    (cnt_r == perc_pkg::ERR_MAX && !rd_err) |=> cnt_r == perc_pkg::ERR_MAX)
    else $error("counter wrapped");
  chk_cnt_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_err && !bump) |=> cnt_r == 8'h00)
    else $error("counter not cleared by read");
  chk_cnt_step: assert property (@(posedge clk) disable iff (!rst_n)
    (!rd_err && cnt_r != perc_pkg::ERR_MAX) |=> (cnt_r - $past(cnt_r)) inside {8'h00, 8'h01})
    else $error("counter jumped");
  chk_cnt_nocol: assert property (@(posedge clk) disable iff (!rst_n)
    (car_d_r && ev_col_r) |-> !bump)
    else $error("count during collision");
  chk_cnt_inc: assert property (@(posedge clk) disable iff (!rst_n)
    (bump && !rd_err && cnt_r != perc_pkg::ERR_MAX) |=> cnt_r == $past(cnt_r) + 8'h01)
    else $error("counter missed event");
  chk_rsvd_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_r & ~perc_pkg::PCS_WMASK) == 16'h0000)
    else $error("reserved bit set");
  chk_quiet_out: assert property (@(posedge clk) disable iff (!rst_n)
    true_quiet_enable == cfg_r[perc_pkg::BIT_QUIET_EN])
    else $error("quiet output mismatch");
  chk_link_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (lst_r == PERC_UP && sig_s && cfg_r[perc_pkg::BIT_SD_POLICY]) |=> lst_r == PERC_UP)
    else $error("link dropped on lock loss");
  chk_link_drop: assert property (@(posedge clk) disable iff (!rst_n)
    (!cfg_r[perc_pkg::BIT_SD_POLICY] && !lock_s) |=> lst_r == PERC_DOWN)
    else $error("link held without lock");
  chk_force_ok: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_r[perc_pkg::BIT_FORCE_OK] |=> link_100_up)
    else $error("forced link not reported");
  cov_bump: cover property (@(posedge clk) disable iff (!rst_n) bump);
  cov_sat: cover property (@(posedge clk) disable iff (!rst_n) cnt_r == perc_pkg::ERR_MAX);
  cov_tout: cover property (@(posedge clk) disable iff (!rst_n) tout_nxt);
  cov_up: cover property (@(posedge clk) disable iff (!rst_n) lst_r == PERC_UP);
endmodule : perc_top
`default_nettype wire

// ---- tb/perc_mac_model.sv ----
// Purpose: management-side apb master standing in for the mac
// Assumes: slave answers with pready; waits are cut by the bench timeout
// Notes:   signals are set by blocking assignment at time zero, then change only by non-blocking assignment after a rising edge
`timescale 1ns/1ps
`default_nettype none
module perc_mac_model (
  // clock
  input  wire logic        clk,
  // apb request
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata,
  // apb answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end

  // one setup cycle, then access until pready is sampled high
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : perc_mac_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for the error counter and coding-sublayer bank
// Assumes: 125 MHz clock, apb zero-wait slave
// Notes:   reference model kept in integers beside the design
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk, rst_n, rx_carrier, rx_symbol_err, rx_collision;
  logic        signal_level_ok, desc_locked, desc_activity;
  logic        psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, w;
  logic [15:0] exp_cfg;
  wire  [6:0]  ctl;
  int          num_errors, checked, cyc, exp_cnt, n;

  // ---------------------------------------------------------------------------
  // clock, partner and design
  // ---------------------------------------------------------------------------
  initial clk = 1'b0;
  always #4 clk = ~clk;

  perc_mac_model mac (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  perc_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_carrier(rx_carrier), .rx_symbol_err(rx_symbol_err), .rx_collision(rx_collision),
    .signal_level_ok(signal_level_ok), .desc_locked(desc_locked),
    .desc_activity(desc_activity), .true_quiet_enable(ctl[6]),
    .forced_signal_detect(ctl[5]), .descrambler_timeout_select(ctl[4]),
    .nrzi_bypass(ctl[3]), .free_rx_clock(ctl[2]), .link_100_up(ctl[1]),
    .desc_timeout(ctl[0]));

  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [11:0] a);
    mac.xfer(1'b0, a, 32'h0000_0000, rdat, rerr);
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    mac.xfer(1'b1, a, d, rdat, rerr);
  endtask : wr

  // one carrier event carrying ne symbol errors
  task automatic ev(input int ne, input logic col);
    @(posedge clk);
    rx_carrier   <= 1'b1;
    rx_collision <= col;
    for (int i = 0; i < ne; i++) begin
      @(posedge clk) rx_symbol_err <= 1'b1;
      @(posedge clk) rx_symbol_err <= 1'b0;
    end
    repeat (2) @(posedge clk);
    rx_carrier   <= 1'b0;
    rx_collision <= 1'b0;
    repeat (6) @(posedge clk);
    if (ne > 0 && !col && exp_cnt < 255) exp_cnt++;
  endtask : ev

  task automatic link(input logic s, input logic l, input logic exp);
    @(posedge clk);
    signal_level_ok <= s;
    desc_locked     <= l;
    repeat (8) @(posedge clk);
    chk({31'h0, ctl[1]}, {31'h0, exp});
  endtask : link

  always @(posedge clk) begin
    cyc++;
    if (cyc == 99000) begin
      num_errors++;
      stop_test;
    end
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {rst_n, rx_carrier, rx_symbol_err, rx_collision} = 4'h0;
    {signal_level_ok, desc_locked, desc_activity} = 3'h0;
    num_errors = 0;
    checked    = 0;
    cyc        = 0;
    exp_cnt    = 0;
    w = $urandom(78971);
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(perc_pkg::ADDR_PCS_CFG);
    chk(rdat, 32'h0000_0100);
    rd(perc_pkg::ADDR_RX_ERR);
    chk(rdat, 32'h0000_0000);
    chk({31'h0, rerr}, 32'h0000_0000);
    for (int k = 0; k < 6; k++) begin
      w = $urandom & {16'h0, perc_pkg::PCS_WMASK | 16'he000};
      exp_cfg = w[15:0] & perc_pkg::PCS_WMASK;
      wr(perc_pkg::ADDR_PCS_CFG, w);
      rd(perc_pkg::ADDR_PCS_CFG);
      chk(rdat, {16'h0, exp_cfg});
      chk({27'h0, ctl[6:2]}, {27'h0, exp_cfg[10], exp_cfg[9], exp_cfg[7], exp_cfg[2],
          exp_cfg[11]});
    end
    wr(perc_pkg::ADDR_RX_ERR, 32'h0000_ffff);
    rd(perc_pkg::ADDR_RX_ERR);
    chk(rdat, 32'h0000_0000);
    ev(3, 1'b0);
    ev(1, 1'b1);
    ev(0, 1'b0);
    ev(2, 1'b0);
    rd(perc_pkg::ADDR_RX_ERR);
    chk(rdat, exp_cnt);
    exp_cnt = 0;
    rd(perc_pkg::ADDR_RX_ERR);
    chk(rdat, exp_cnt);
    repeat (257) ev(1 + $urandom % 3, 1'b0);
    rd(perc_pkg::ADDR_RX_ERR);
    chk(rdat, exp_cnt);
    exp_cnt = 0;
    desc_activity <= 1'b1;
    wr(perc_pkg::ADDR_PCS_CFG, 32'h0000_0100);
    link(1'b1, 1'b1, 1'b1);
    link(1'b1, 1'b0, 1'b1);
    link(1'b0, 1'b0, 1'b0);
    wr(perc_pkg::ADDR_PCS_CFG, 32'h0000_0000);
    link(1'b1, 1'b1, 1'b1);
    link(1'b1, 1'b0, 1'b0);
    wr(perc_pkg::ADDR_PCS_CFG, 32'h0000_0020);
    link(1'b0, 1'b0, 1'b1);
    rd(perc_pkg::ADDR_LINK_STAT);
    chk(rdat, 32'h0000_0001);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(perc_pkg::ADDR_PCS_CFG);
    chk(rdat, 32'h0000_0100);
    chk({31'h0, ctl[1]}, 32'h0000_0000);
    rd(12'h100);
    chk({31'h0, rerr}, 32'h0000_0001);
    wr(perc_pkg::ADDR_PCS_CFG, 32'h0000_0100);
    link(1'b1, 1'b1, 1'b1);
    desc_activity <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ctl[0] !== 1'b1 && n < 95000);
    chk({31'h0, n >= perc_pkg::DESC_SHORT_CYC - 6 && n <= perc_pkg::DESC_SHORT_CYC + 6},
        32'h0000_0001);
    stop_test;
  end
endmodule : testbench
`default_nettype wire
